/* hdl/eci_pkg.sv */
// Constants and carrier types for the event cache error insertion block
package eci_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int unsigned REG_ADDR_W = 16;
  localparam logic [15:0] EVENT_CACHE_ERROR_INSERT_OFFSET = 16'h0000;
  localparam int unsigned REG_W = 64;
  localparam logic [63:0] RDATA_RESET = 64'h0000_0000_0000_0000;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned START_BIT = 63;
  localparam int unsigned STATUS_LSB = 61;
  localparam int unsigned STATUS_W = 2;
  localparam int unsigned ENC_OFF_BIT = 60;
  localparam int unsigned RAM_PRESENT_BIT = 60;
  localparam int unsigned ADDR_LSB = 32;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned SECOND_EN_BIT = 31;
  localparam int unsigned SECOND_LOC_LSB = 16;
  localparam int unsigned FIRST_EN_BIT = 15;
  localparam int unsigned FIRST_LOC_LSB = 0;
  localparam int unsigned LOC_W = 9;

  // ************************************************************
  // Result codes
  // ************************************************************
  localparam logic [1:0] STATUS_DONE = 2'h0;
  localparam logic [1:0] STATUS_RANGE = 2'h1;
  localparam logic [1:0] STATUS_COINCIDENT = 2'h2;
  localparam logic [1:0] STATUS_MISMATCH = 2'h3;
  localparam logic [1:0] STATUS_RESET = 2'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    ECI_IDLE = 2'h0,
    ECI_READ = 2'h1,
    ECI_WRITE = 2'h3
  } eci_state_e;

  typedef struct packed {
    logic enc_off;
    logic [15:0] addr;
    logic second_en;
    logic [8:0] second_loc;
    logic first_en;
    logic [8:0] first_loc;
  } eci_cfg_s;

  localparam eci_cfg_s CFG_RESET = '0;

  typedef struct packed {
    logic valid;
    logic we;
    logic [15:0] addr;
  } eci_ram_req_s;

  localparam eci_ram_req_s RAM_REQ_RESET = '0;

endpackage

/* hdl/eci_fault_mask.sv */
// Builds the bit-flip mask for the selected fault locations
`timescale 1ns/1ps
module eci_fault_mask #(
  parameter int unsigned RAM_W = 64
) (
  input wire eci_pkg::eci_cfg_s cfg_in,
  output logic [RAM_W-1:0] mask_out,
  output logic range_err_out,
  output logic coincide_out
);

  // ************************************************************
  // One flip per enabled location; disabled locations are ignored
  // ************************************************************
  for (genvar i = 0; i < RAM_W; i++) begin : g_bit
    assign mask_out[i] = (cfg_in.first_en && (cfg_in.first_loc == i[8:0]))
      | (cfg_in.second_en && (cfg_in.second_loc == i[8:0]));
  end

  // Locations beyond the word are refused before the RAM is touched
  assign range_err_out = (cfg_in.first_en && (32'(cfg_in.first_loc) >= RAM_W))
    | (cfg_in.second_en && (32'(cfg_in.second_loc) >= RAM_W));

  // Two faults on one bit would cancel, so they are reported instead
  assign coincide_out = cfg_in.first_en && cfg_in.second_en
    && (cfg_in.first_loc == cfg_in.second_loc);

endmodule

/* hdl/eci_check_enc.sv */
// Check-bit encoder used to verify entries before corrupting them
`timescale 1ns/1ps
module eci_check_enc #(
  parameter int unsigned RAM_W = 64,
  parameter int unsigned CHK_W = 8
) (
  input wire logic [RAM_W-1:0] data_in,
  output logic [CHK_W-1:0] check_out
);

  // ************************************************************
  // Interleaved parity: check bit k covers data bits i with i mod CHK_W == k
  // ************************************************************
  for (genvar k = 0; k < CHK_W; k++) begin : g_chk
    logic [RAM_W-1:0] sel;
    for (genvar i = 0; i < RAM_W; i++) begin : g_bit
      assign sel[i] = ((i % CHK_W) == k) ? data_in[i] : 1'b0;
    end
    assign check_out[k] = ^sel;
  end

endmodule

/* hdl/eci_error_insert.sv */
// Event cache ECC error insertion register and injection engine
`timescale 1ns/1ps

// Contract
// - Writing 1 to bit 63 starts an injection and the device clears it when done.
// - A read of bit 63 shows 1 while an injection runs and 0 once it is complete.
// - Written bit 60 at 0 keeps the encoder check during injection, at 1 skips it.
// - With the second enable set the second location bit is flipped, else ignored.
// - With the first enable set the first location bit is flipped, else ignored.
// - The two-bit status (done, range, coincident, mismatch) holds once bit 63 is 0.
// - A read of bit 60 shows 1 only when an ECC-protected RAM is present.
// - A read of bits 47 to 32 returns the highest valid event cache address.
// - A read of bits 8 to 0 returns the RAM width minus one.
// - With nonsecure access disallowed only secure transactions reach the register.
// - In multi-view builds only view 0 reaches the register.
// - The register exists only when the event cache has ECC protection.
module eci_error_insert #(
  parameter int unsigned RAM_W = 64,
  parameter int unsigned CHK_W = 8,
  parameter int unsigned RAM_DEPTH = 256,
  parameter int unsigned VIEW_W = 2,
  parameter bit ECC_PRESENT = 1'b1
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [63:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_secure_in,
  input wire logic [VIEW_W-1:0] reg_view_in,
  input wire logic nonsecure_access_allow_in,
  input wire logic multi_view_in,
  output logic [63:0] reg_rdata_out,
  output eci_pkg::eci_ram_req_s ram_req_out,
  output logic [RAM_W-1:0] ram_wdata_out,
  output logic [CHK_W-1:0] ram_wcheck_out,
  input wire logic ram_ack_in,
  input wire logic [RAM_W-1:0] ram_rdata_in,
  input wire logic [CHK_W-1:0] ram_rcheck_in,
  input wire logic ram_rerr_in
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (RAM_W < 1 || RAM_W > 512) begin : g_bad_width
    $error("RAM_W must lie between 1 and 512");
  end
  if (RAM_DEPTH < 1 || RAM_DEPTH > 65536) begin : g_bad_depth
    $error("RAM_DEPTH must lie between 1 and 65536");
  end
  if (CHK_W < 1 || CHK_W > RAM_W) begin : g_bad_chk
    $error("CHK_W must lie between 1 and RAM_W");
  end

  localparam logic [15:0] RAM_MAX = 16'(RAM_DEPTH - 1);
  localparam logic [8:0] WIDTH_IDX = 9'(RAM_W - 1);

  // ************************************************************
  // Access filter
  // ************************************************************
  // Refused accesses are silent: writes vanish and reads return zero
  function automatic logic access_ok(input logic secure, input logic [VIEW_W-1:0] view,
                                     input logic ns_allow, input logic multi_view);
    logic ok;
    ok = ECC_PRESENT;
    ok = ok && (ns_allow || secure);
    ok = ok && (!multi_view || (view == '0));
    return ok;
  endfunction

  logic hit;
  logic allowed;
  logic wr_ok;
  logic rd_ok;
  assign hit = (reg_addr_in == eci_pkg::EVENT_CACHE_ERROR_INSERT_OFFSET);
  assign allowed = access_ok(reg_secure_in, reg_view_in, nonsecure_access_allow_in,
                             multi_view_in);
  assign wr_ok = reg_wr_in && hit && allowed;
  assign rd_ok = reg_rd_in && hit && allowed;

  // ************************************************************
  // Configuration fields
  // ************************************************************
  eci_pkg::eci_state_e state_r;
  eci_pkg::eci_state_e state_nxt;
  eci_pkg::eci_cfg_s cfg_r;
  eci_pkg::eci_cfg_s cfg_nxt;
  logic busy_r;
  logic [1:0] status_r;
  logic start;

  // Fields are frozen while an injection runs so the target cannot move under it
  assign start = wr_ok && !busy_r && reg_wdata_in[eci_pkg::START_BIT];

  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_ok && !busy_r) begin
      // Only named fields are captured; reserved bits fall away
      cfg_nxt.enc_off = reg_wdata_in[eci_pkg::ENC_OFF_BIT];
      cfg_nxt.addr = reg_wdata_in[eci_pkg::ADDR_LSB +: eci_pkg::ADDR_W];
      cfg_nxt.second_en = reg_wdata_in[eci_pkg::SECOND_EN_BIT];
      cfg_nxt.second_loc = reg_wdata_in[eci_pkg::SECOND_LOC_LSB +: eci_pkg::LOC_W];
      cfg_nxt.first_en = reg_wdata_in[eci_pkg::FIRST_EN_BIT];
      cfg_nxt.first_loc = reg_wdata_in[eci_pkg::FIRST_LOC_LSB +: eci_pkg::LOC_W];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cfg_r <= eci_pkg::CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ************************************************************
  // Mask and encoder
  // ************************************************************
  logic [RAM_W-1:0] mask;
  logic range_err;
  logic coincide;
  logic [CHK_W-1:0] calc_check;
  logic addr_err;

  eci_fault_mask #(
    .RAM_W(RAM_W)
  ) u_mask (
    .cfg_in(cfg_nxt),
    .mask_out(mask),
    .range_err_out(range_err),
    .coincide_out(coincide)
  );

  eci_check_enc #(
    .RAM_W(RAM_W),
    .CHK_W(CHK_W)
  ) u_enc (
    .data_in(ram_rdata_in),
    .check_out(calc_check)
  );

  assign addr_err = (cfg_nxt.addr > RAM_MAX);

  // ************************************************************
  // Injection sequencer
  // ************************************************************
  // Read the entry, check it, then write it back with the flips applied
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      eci_pkg::ECI_IDLE: begin
        if (start && !range_err && !addr_err && !coincide) begin
          state_nxt = eci_pkg::ECI_READ;
        end
      end
      eci_pkg::ECI_READ: begin
        if (ram_ack_in) begin
          if (ram_rerr_in || (!cfg_r.enc_off && (calc_check != ram_rcheck_in))) begin
            state_nxt = eci_pkg::ECI_IDLE;
          end else begin
            state_nxt = eci_pkg::ECI_WRITE;
          end
        end
      end
      eci_pkg::ECI_WRITE: begin
        if (ram_ack_in) begin
          state_nxt = eci_pkg::ECI_IDLE;
        end
      end
      default: begin
        state_nxt = eci_pkg::ECI_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_r <= eci_pkg::ECI_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Busy mirrors the start bit; it drops on the edge the sequencer returns to ECI_IDLE
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt != eci_pkg::ECI_IDLE);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      status_r <= eci_pkg::STATUS_RESET;
    end else if (state_r == eci_pkg::ECI_IDLE && start) begin
      if (range_err || addr_err) begin
        status_r <= eci_pkg::STATUS_RANGE;
      end else if (coincide) begin
        status_r <= eci_pkg::STATUS_COINCIDENT;
      end else begin
        status_r <= eci_pkg::STATUS_DONE;
      end
    end else if (state_r == eci_pkg::ECI_READ && ram_ack_in) begin
      if (ram_rerr_in) begin
        status_r <= eci_pkg::STATUS_COINCIDENT;
      end else if (!cfg_r.enc_off && (calc_check != ram_rcheck_in)) begin
        status_r <= eci_pkg::STATUS_MISMATCH;
      end
    end
  end

  // ************************************************************
  // RAM port
  // ************************************************************
  logic [RAM_W-1:0] flip_mask_r;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      flip_mask_r <= '0;
    end else if (start) begin
      flip_mask_r <= mask;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ram_req_out <= eci_pkg::RAM_REQ_RESET;
    end else begin
      ram_req_out.valid <= (state_nxt != eci_pkg::ECI_IDLE);
      ram_req_out.we <= (state_nxt == eci_pkg::ECI_WRITE);
      ram_req_out.addr <= cfg_nxt.addr;
    end
  end

  // Old check bits are kept so that the flips show as ECC errors later
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ram_wdata_out <= '0;
      ram_wcheck_out <= '0;
    end else if (state_r == eci_pkg::ECI_READ && ram_ack_in) begin
      ram_wdata_out <= ram_rdata_in ^ flip_mask_r;
      ram_wcheck_out <= ram_rcheck_in;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [63:0] rd_word;

  always_comb begin
    rd_word = '0;
    rd_word[eci_pkg::START_BIT] = busy_r;
    rd_word[eci_pkg::STATUS_LSB +: eci_pkg::STATUS_W] = status_r;
    rd_word[eci_pkg::RAM_PRESENT_BIT] = ECC_PRESENT;
    rd_word[eci_pkg::ADDR_LSB +: eci_pkg::ADDR_W] = RAM_MAX;
    rd_word[eci_pkg::FIRST_LOC_LSB +: eci_pkg::LOC_W] = WIDTH_IDX;
  end

  // Data stand for one cycle only; every other cycle reads zero
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= eci_pkg::RDATA_RESET;
    end else if (rd_ok) begin
      reg_rdata_out <= rd_word;
    end else begin
      reg_rdata_out <= eci_pkg::RDATA_RESET;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  property p_start_busy;
    start && !range_err && !addr_err && !coincide |=> busy_r && ram_req_out.valid
      && !ram_req_out.we;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not raise busy");

  property p_read_busy;
    rd_ok |=> reg_rdata_out[63] == $past(busy_r);
  endproperty
  a_read_busy: assert property (p_read_busy) else $error("bit 63 not busy");

  property p_range;
    start && range_err |=> !busy_r && reg_rdata_out == 64'h0000_0000_0000_0000
      ##0 status_r == eci_pkg::STATUS_RANGE;
  endproperty
  a_range: assert property (p_range) else $error("range error not reported");

  property p_enc_off;
    state_r == eci_pkg::ECI_READ && ram_ack_in && cfg_r.enc_off && !ram_rerr_in
      |=> state_r == eci_pkg::ECI_WRITE;
  endproperty
  a_enc_off: assert property (p_enc_off) else $error("encoder check not skipped");

  property p_addr;
    ram_req_out.valid |-> ram_req_out.addr == cfg_r.addr;
  endproperty
  a_addr: assert property (p_addr) else $error("RAM address differs from field");

  property p_flip;
    state_r == eci_pkg::ECI_READ && ram_ack_in && !ram_rerr_in
      |=> ram_wdata_out == ($past(ram_rdata_in) ^ flip_mask_r);
  endproperty
  a_flip: assert property (p_flip) else $error("written word lacks the flips");

  property p_reserved;
    rd_ok |=> reg_rdata_out[59:48] == 12'h000 && reg_rdata_out[31:9] == 23'h00_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_secure;
    reg_rd_in && !reg_secure_in && !nonsecure_access_allow_in
      |=> reg_rdata_out == 64'h0000_0000_0000_0000;
  endproperty
  a_secure: assert property (p_secure) else $error("nonsecure read not refused");

  property p_view;
    reg_wr_in && multi_view_in && reg_view_in != '0 |=> $stable(cfg_r) && !$rose(busy_r);
  endproperty
  a_view: assert property (p_view) else $error("write from other view taken");

  property p_info;
    rd_ok |=> reg_rdata_out[47:32] == RAM_MAX && reg_rdata_out[8:0] == WIDTH_IDX
      && reg_rdata_out[60] == ECC_PRESENT;
  endproperty
  a_info: assert property (p_info) else $error("RAM info fields wrong");

endmodule

/* verif/eci_error_insert_tb.sv */
// Self-checking testbench for the event cache error insertion block
`timescale 1ns/1ps
module eci_error_insert_tb;
  // ****************************************
  // Signals and design instance
  // ****************************************
  localparam int unsigned DEPTH = 256;
  localparam int unsigned WID = 64;
  logic mclk_in = 1'b0;
  logic rst_n_in;
  logic [15:0] reg_addr_in;
  logic [63:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic reg_secure_in;
  logic [1:0] reg_view_in;
  logic ns_allow;
  logic multi_view;
  logic [63:0] reg_rdata_out;
  eci_pkg::eci_ram_req_s ram_req_out;
  logic [63:0] ram_wdata_out;
  logic [7:0] ram_wcheck_out;
  logic ram_ack_in;
  logic [63:0] ram_rdata_in;
  logic [7:0] ram_rcheck_in;
  logic ram_rerr_in;
  int fails = 0;
  int num_checks = 0;
  logic [63:0] exp_q[$];
  logic [63:0] care_q[$];
  logic pend = 1'b0;

  always #2 mclk_in = ~mclk_in;

  eci_error_insert #(.RAM_W(WID), .CHK_W(8), .RAM_DEPTH(DEPTH), .VIEW_W(2),
    .ECC_PRESENT(1'b1)) dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_secure_in(reg_secure_in), .reg_view_in(reg_view_in),
    .nonsecure_access_allow_in(ns_allow), .multi_view_in(multi_view),
    .reg_rdata_out(reg_rdata_out), .ram_req_out(ram_req_out), .ram_wdata_out(ram_wdata_out),
    .ram_wcheck_out(ram_wcheck_out), .ram_ack_in(ram_ack_in), .ram_rdata_in(ram_rdata_in),
    .ram_rcheck_in(ram_rcheck_in), .ram_rerr_in(ram_rerr_in));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [63:0] exp_word(input logic busy, input logic [1:0] st);
    exp_word = {busy, st, 1'b1, 12'h000, 16'(DEPTH - 1), 23'h00_0000, 9'(WID - 1)};
  endfunction

  // Interleaved parity, the encoder the device checks stored entries against
  function automatic logic [7:0] par(input logic [63:0] d);
    par = 8'h00;
    for (int i = 0; i < 64; i++) begin
      par[i % 8] ^= d[i];
    end
  endfunction

  // Read data is due one cycle after the strobe edge and zero at all other times
  always @(posedge mclk_in) begin
    if (pend) begin
      check("reg_rdata_out", reg_rdata_out & care_q[0], exp_q[0] & care_q[0]);
      void'(exp_q.pop_front());
      void'(care_q.pop_front());
    end else if (rst_n_in) begin
      check("rdata_idle", reg_rdata_out, 64'h0000_0000_0000_0000);
    end
    pend <= reg_rd_in;
  end

  task automatic reg_op(input logic wr, input logic [15:0] a, input logic [63:0] d,
                        input logic sec, input logic [1:0] v, input logic [63:0] exp,
                        input logic [63:0] care);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_secure_in <= sec;
    reg_view_in <= v;
    if (wr) begin
      reg_wr_in <= 1'b1;
    end else begin
      reg_rd_in <= 1'b1;
      exp_q.push_back(exp);
      care_q.push_back(care);
    end
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
  endtask

  task automatic idle_ram(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      check("ram_idle", 64'(ram_req_out.valid), 64'h0000_0000_0000_0000);
    end
  endtask

  // Plays the RAM: answers the read, then the write if one is due
  task automatic ram_serve(input logic [15:0] a, input logic [63:0] d, input logic [7:0] c,
                           input logic rerr, input logic wr_exp, input logic [63:0] mask);
    int n;
    n = 0;
    @(posedge mclk_in);
    while (ram_req_out.valid !== 1'b1 && n < 50) begin
      @(posedge mclk_in);
      n++;
    end
    repeat ($urandom_range(5, 2)) @(posedge mclk_in);
    check("ram_read_req", 64'(ram_req_out), 64'({2'b10, a}));
    ram_ack_in <= 1'b1;
    ram_rdata_in <= d;
    ram_rcheck_in <= c;
    ram_rerr_in <= rerr;
    @(posedge mclk_in);
    ram_ack_in <= 1'b0;
    ram_rdata_in <= ~d;
    ram_rcheck_in <= ~c;
    ram_rerr_in <= 1'b0;
    if (wr_exp) begin
      @(posedge mclk_in);
      check("ram_write_req", 64'(ram_req_out), 64'({2'b11, a}));
      check("ram_wdata_out", ram_wdata_out, d ^ mask);
      check("ram_wcheck_out", 64'(ram_wcheck_out), 64'(c));
      repeat ($urandom_range(3, 0)) @(posedge mclk_in);
      ram_ack_in <= 1'b1;
      @(posedge mclk_in);
      ram_ack_in <= 1'b0;
    end
  endtask

  // ram: 0 no access, 1 read only, 2 read then write
  task automatic inject(input logic off, input logic [15:0] a, input logic e2,
                        input logic [8:0] l2, input logic e1, input logic [8:0] l1,
                        input logic [7:0] cerr, input logic rerr, input int ram,
                        input logic [1:0] st);
    logic [63:0] d;
    logic [63:0] mask;
    d = {$urandom, $urandom};
    mask = 64'h0000_0000_0000_0000;
    if (e1 && l1 < 64) mask[l1[5:0]] = 1'b1;
    if (e2 && l2 < 64) mask[l2[5:0]] = mask[l2[5:0]] ^ 1'b1;
    // Reserved write bits are all set so any leak into the engine shows
    reg_op(1'b1, 16'h0000, {1'b1, 2'b11, off, 12'hfff, a, e2, 6'h3f, l2, e1, 6'h3f, l1},
           1'b1, 2'h0, '0, '0);
    if (ram != 0) begin
      fork
        ram_serve(a, d, par(d) ^ cerr, rerr, ram == 2, mask);
        begin
          reg_op(1'b0, 16'h0000, '0, 1'b1, 2'h0, exp_word(1'b1, 2'h0),
                 64'h8000_0000_0000_0000);
          // A start while busy must be dropped whole
          reg_op(1'b1, 16'h0000, {1'b1, 15'h0000, ~a, 32'h8000_8000}, 1'b1, 2'h0, '0, '0);
        end
      join
    end
    idle_ram(3);
    reg_op(1'b0, 16'h0000, '0, 1'b1, 2'h0, exp_word(1'b0, st), '1);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [15:0] a;
    logic [8:0] l1;
    logic [8:0] l2;
    rst_n_in = 1'b0;
    reg_addr_in = 16'h0000;
    reg_wdata_in = '0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_secure_in = 1'b0;
    reg_view_in = 2'h0;
    ns_allow = 1'b0;
    multi_view = 1'b0;
    ram_ack_in = 1'b0;
    ram_rdata_in = '0;
    ram_rcheck_in = 8'h00;
    ram_rerr_in = 1'b0;
    void'($urandom(37));
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      ns_allow <= 6'b000100 >> i;
      multi_view <= 6'b011000 >> i;
      a = (i == 5) ? 16'h0008 : 16'h0000;
      reg_op(1'b0, a, '0, 6'b111001 >> i, {1'b0, 6'b001000 >> i},
             (6'b010101 >> i) & 1 ? exp_word(1'b0, eci_pkg::STATUS_RESET) : '0, '1);
      if (!((6'b010101 >> i) & 1)) begin
        reg_op(1'b1, a, {1'b1, 23'h00_0000, 16'h0001, 24'h00_8001}, 6'b111001 >> i,
               {1'b0, 6'b001000 >> i}, '0, '0);
        idle_ram(3);
      end
    end
    ns_allow <= 1'b0;
    multi_view <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      a = 16'($urandom_range(DEPTH - 1));
      l1 = 9'($urandom_range(WID - 1));
      l2 = 9'((l1 + 1 + $urandom_range(WID - 2)) % WID);
      inject(1'b0, a, 1'b1, l2, 1'b1, l1, 8'h00, 1'b0, 2, eci_pkg::STATUS_DONE);
    end
    inject(1'b0, a, 1'b0, l1, 1'b1, l1, 8'h00, 1'b0, 2, eci_pkg::STATUS_DONE);
    inject(1'b0, a, 1'b1, l2, 1'b0, 9'h1ff, 8'h00, 1'b0, 2, eci_pkg::STATUS_DONE);
    inject(1'b0, a, 1'b1, l1, 1'b1, l2, 8'h04, 1'b0, 1, eci_pkg::STATUS_MISMATCH);
    inject(1'b1, a, 1'b1, l1, 1'b1, l2, 8'h04, 1'b0, 2, eci_pkg::STATUS_DONE);
    inject(1'b0, a, 1'b1, l1, 1'b1, l2, 8'h00, 1'b1, 1, eci_pkg::STATUS_COINCIDENT);
    inject(1'b0, a, 1'b1, l1, 1'b1, l1, 8'h00, 1'b0, 0, eci_pkg::STATUS_COINCIDENT);
    inject(1'b0, a, 1'b0, l2, 1'b1, 9'h040, 8'h00, 1'b0, 0, eci_pkg::STATUS_RANGE);
    inject(1'b0, 16'h0100, 1'b0, l2, 1'b1, l1, 8'h00, 1'b0, 0, eci_pkg::STATUS_RANGE);
    inject(1'b0, 16'h00ff, 1'b1, 9'h03f, 1'b1, 9'h000, 8'h00, 1'b0, 2, eci_pkg::STATUS_DONE);
    conclude();
  end

  initial begin
    repeat (5000) @(posedge mclk_in);
    fails++;
    conclude();
  end
endmodule
